// >>> hdl/rtcap_div.sv
// divider: 256 Hz tick and a free tick count for the rtc block
// assumes clr and run come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module rtcap_div
    import rtcap_pkg::*;
#(
    parameter int DIV_CYC = DIV256_CYC,
    parameter int CNT_W   = TCNT_W
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             run,
    input  wire logic             clr,
    output logic                  tick,
    output logic [CNT_W-1:0]      cnt
);
    localparam int PRE_W = $clog2(DIV_CYC);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(DIV_CYC - 1);

    typedef struct packed {
        logic [PRE_W-1:0] pre;
        logic [CNT_W-1:0] cnt;
        logic             tick;
    } rtcap_div_st_t;

    rtcap_div_st_t q;
    rtcap_div_st_t d;

    // ======================================================
    // prescaler; clr restarts the phase so the next second is whole
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (clr) begin
            d.pre = '0;
            d.cnt = '0;
        end else if (run) begin
            if (q.pre == PRE_LAST) begin
                d.pre  = '0;
                d.cnt  = q.cnt + CNT_W'(1);
                d.tick = 1'b1;
            end else begin
                d.pre = q.pre + PRE_W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;
    assign cnt  = q.cnt;
endmodule
`default_nettype wire

// >>> hdl/rtcap_top.sv
// rtc calendar, alarm comparison and periodic interrupt
// assumes a same-clock register master: one-cycle strobes, read data next cycle
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rtcap_top
    import rtcap_pkg::*;
#(
    parameter int DIV_CYC = DIV256_CYC
) (
    input  wire logic       CLK,
    input  wire logic       RSTN,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    output logic            IRQ
);
    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hr;
        logic [7:0] wk;
        logic [7:0] day;
        logic [7:0] mon;
        logic [7:0] yr;
        logic [7:0] sec_al;
        logic [7:0] min_al;
        logic [7:0] hr_al;
        logic [7:0] wk_al;
        logic [7:0] day_al;
        logic [7:0] mon_al;
        logic [7:0] yr_al;
        logic       year_alarm_enable;
        logic       af;
        logic       alarm_irq_enable;
        logic       periodic_flag;
        logic [2:0] psel;
        logic       osc_en;
        logic       start;
        logic [1:0] sts;
        logic [1:0] msk;
        logic       upd;
        logic [7:0] rdata;
        logic       irq;
    } rtcap_st_t;

    localparam rtcap_st_t ST_RST = '{start: RUN_START_RST, osc_en: RUN_OSC_RST, default: '0};

    rtcap_st_t          q;
    rtcap_st_t          d;
    logic               tick;
    logic [TCNT_W-1:0]  tcnt;
    logic               div_clr;
    logic               sec_tick;
    logic               per_evt;
    logic               match;
    logic               any_en;
    logic               alarm_evt;
    logic               af_clr;
    logic [1:0]         w1c;
    logic [7:0]         day_last;

    // ======================================================
    // helpers
    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] last,
                                           input logic [7:0] first);
        if (v == last) begin
            return first;
        end else if (v[3:0] == BCD_NINE) begin
            return {v[7:4] + 4'h1, 4'h0};
        end else begin
            return {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // field with its enable clear is ignored; value sits in the low seven bits
    function automatic logic field_ok(input logic [7:0] al, input logic [7:0] cnt);
        return !al[ALM_EN_BIT] || (al[6:0] == cnt[6:0]);
    endfunction

    // leap years by bcd: only the two-digit year is known, every fourth year
    function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        if (mon == MON_FEB) begin
            return leap ? DAY_L29 : DAY_L28;
        end else if (mon == MON_APR || mon == MON_JUN || mon == MON_SEP || mon == MON_NOV) begin
            return DAY_L30;
        end else begin
            return DAY_L31;
        end
    endfunction

    // ======================================================
    // divider keeps running with the counters halted; only the oscillator enable stops it
    rtcap_div #(
        .DIV_CYC (DIV_CYC),
        .CNT_W   (TCNT_W)
    ) u_div (
        .clk  (CLK),
        .rstn (RSTN),
        .run  (q.osc_en),
        .clr  (div_clr),
        .tick (tick),
        .cnt  (tcnt)
    );

    // ======================================================
    // events decoded from the tick count
    assign div_clr  = WR && (ADDR == A_RUNCTL) && WDATA[DRST_BIT];
    assign sec_tick = tick && ((tcnt & SEC_MASK) == '0);
    // interval in ticks is a power of two chosen by the select code
    assign per_evt  = tick && (q.psel != PSEL_NONE) &&
                      ((tcnt & TCNT_W'((10'h1 << PER_LOG2[q.psel]) - 10'h1)) == '0);
    assign day_last = month_last(q.mon, q.yr);

    // alarm compare; with nothing enabled no alarm is raised at all
    assign any_en = q.sec_al[ALM_EN_BIT] | q.min_al[ALM_EN_BIT] | q.hr_al[ALM_EN_BIT] |
                    q.wk_al[ALM_EN_BIT] | q.day_al[ALM_EN_BIT] | q.mon_al[ALM_EN_BIT] | q.year_alarm_enable;
    assign match  = any_en && field_ok(q.sec_al, q.sec) && field_ok(q.min_al, q.min) &&
                    field_ok(q.hr_al, q.hr) && field_ok(q.wk_al, q.wk) &&
                    field_ok(q.day_al, q.day) && field_ok(q.mon_al, q.mon) &&
                    (!q.year_alarm_enable || q.yr_al == q.yr);
    // compared the cycle after the counters moved, so each matching second counts once
    assign alarm_evt = q.upd && match;

    assign af_clr = WR && (ADDR == A_ALCTL) && !WDATA[AF_BIT];
    assign w1c    = (WR && ADDR == A_ISTS) ? WDATA[1:0] : 2'h0;

    // ======================================================
    // next state
    always_comb begin
        d = q;
        d.upd = q.start && sec_tick;
        // counting; carries ripple in the same cycle
        if (q.start && sec_tick) begin
            d.sec = bcd_inc(q.sec, SEC_LAST, BCD_ZERO);
            if (q.sec == SEC_LAST) begin
                d.min = bcd_inc(q.min, SEC_LAST, BCD_ZERO);
                if (q.min == SEC_LAST) begin
                    d.hr = bcd_inc(q.hr, HR_LAST, BCD_ZERO);
                    if (q.hr == HR_LAST) begin
                        d.wk  = bcd_inc(q.wk, WK_LAST, BCD_ZERO);
                        d.day = bcd_inc(q.day, day_last, BCD_ONE);
                        if (q.day == day_last) begin
                            d.mon = bcd_inc(q.mon, MON_LAST, BCD_ONE);
                            if (q.mon == MON_LAST) begin
                                d.yr = bcd_inc(q.yr, YR_LAST, BCD_ZERO);
                            end
                        end
                    end
                end
            end
        end
        // register writes; counters only take a write while halted
        if (WR) begin
            unique case (ADDR)
                A_SEC: if (!q.start) d.sec = WDATA;
                A_MIN: if (!q.start) d.min = WDATA;
                A_HR: if (!q.start) d.hr = WDATA;
                A_WK: if (!q.start) d.wk = WDATA;
                A_DAY: if (!q.start) d.day = WDATA;
                A_MON: if (!q.start) d.mon = WDATA;
                A_YR: if (!q.start) d.yr = WDATA;
                A_SECAL: d.sec_al = WDATA;
                A_MINAL: d.min_al = WDATA;
                A_HRAL: d.hr_al = WDATA;
                A_WKAL: d.wk_al = WDATA;
                A_DAYAL: d.day_al = WDATA;
                A_MONAL: d.mon_al = WDATA;
                A_YRAL: d.yr_al = WDATA;
                A_ALCTL: d.alarm_irq_enable = WDATA[AIE_BIT];
                A_RUNCTL: begin
                    d.start  = WDATA[START_BIT];
                    d.osc_en = WDATA[OSC_BIT];
                    d.psel   = WDATA[PSEL_LSB +: 3];
                end
                A_YRCTL: d.year_alarm_enable = WDATA[YEAR_ALARM_ENABLE_BIT];
                A_IMSK: d.msk = WDATA[1:0];
                default: ;
            endcase
        end
        // sticky flags: a set in the clearing cycle wins
        d.af = alarm_evt || (q.af && !af_clr);
        d.sts = (q.sts & ~w1c) | {per_evt, alarm_evt};
        // periodic flag marks the elapsed interval until the interrupt takes it over
        if (per_evt) begin
            d.periodic_flag = 1'b1;
        end else if (q.periodic_flag && q.psel != PSEL_NONE && q.sts[IRQ_PER]) begin
            d.periodic_flag = 1'b0;
        end
        // alarm source is gated by the alarm interrupt enable as well as by the mask
        d.irq = |(q.sts & q.msk & {1'b1, q.alarm_irq_enable});
        // read data stand only in the cycle after the strobe
        d.rdata = 8'h00;
        if (RD) begin
            unique case (ADDR)
                A_SEC: d.rdata = q.sec;
                A_MIN: d.rdata = q.min;
                A_HR: d.rdata = q.hr;
                A_WK: d.rdata = q.wk;
                A_DAY: d.rdata = q.day;
                A_MON: d.rdata = q.mon;
                A_YR: d.rdata = q.yr;
                A_SECAL: d.rdata = q.sec_al;
                A_MINAL: d.rdata = q.min_al;
                A_HRAL: d.rdata = q.hr_al;
                A_WKAL: d.rdata = q.wk_al;
                A_DAYAL: d.rdata = q.day_al;
                A_MONAL: d.rdata = q.mon_al;
                A_YRAL: d.rdata = q.yr_al;
                A_ALCTL: begin
                    d.rdata[AF_BIT]  = q.af;
                    d.rdata[AIE_BIT] = q.alarm_irq_enable;
                end
                A_RUNCTL: begin
                    d.rdata[PEF_BIT]       = q.periodic_flag;
                    d.rdata[PSEL_LSB +: 3] = q.psel;
                    d.rdata[OSC_BIT]       = q.osc_en;
                    d.rdata[START_BIT]     = q.start;
                end
                A_YRCTL: d.rdata[YEAR_ALARM_ENABLE_BIT] = q.year_alarm_enable;
                A_ISTS: d.rdata[1:0] = q.sts;
                A_IMSK: d.rdata[1:0] = q.msk;
                default: ;
            endcase
        end
    end

    // state register
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign RDATA = q.rdata;
    assign IRQ   = q.irq;

    // ======================================================
    // checks
    chk_yrctl_low_zero: assert property (@(posedge CLK) disable iff (!RSTN)
        RD && ADDR == A_YRCTL |=> RDATA[6:0] == 7'h00)
        else $error("year alarm control low bits not zero");

    chk_cnt_wr_refused: assert property (@(posedge CLK) disable iff (!RSTN)
        WR && ADDR == A_SEC && q.start && !sec_tick |=> q.sec == $past(q.sec))
        else $error("seconds counter written while running");

    chk_match_sets_af: assert property (@(posedge CLK) disable iff (!RSTN)
        q.upd && match |=> q.af && q.sts[IRQ_ALM])
        else $error("alarm match did not set the flag");

    chk_af_needs_match: assert property (@(posedge CLK) disable iff (!RSTN)
        $rose(q.af) |-> $past(q.upd) && $past(match))
        else $error("alarm flag rose without a full match");

    chk_year_compared: assert property (@(posedge CLK) disable iff (!RSTN)
        q.upd && q.year_alarm_enable && q.yr_al != q.yr |=> !$rose(q.af))
        else $error("year mismatch raised alarm");

    chk_alarm_irq_on: assert property (@(posedge CLK) disable iff (!RSTN)
        q.sts[IRQ_ALM] && q.msk[IRQ_ALM] && q.alarm_irq_enable |=> IRQ)
        else $error("enabled alarm did not interrupt");

    chk_alarm_irq_off: assert property (@(posedge CLK) disable iff (!RSTN)
        !q.alarm_irq_enable && !q.sts[IRQ_PER] |=> !IRQ)
        else $error("alarm interrupt without enable");

    chk_per_flag_set: assert property (@(posedge CLK) disable iff (!RSTN)
        per_evt |=> q.periodic_flag && q.sts[IRQ_PER])
        else $error("periodic flag or status not set");

    chk_per_flag_clr: assert property (@(posedge CLK) disable iff (!RSTN)
        q.periodic_flag && q.psel != PSEL_NONE && q.sts[IRQ_PER] && !per_evt |=> !q.periodic_flag)
        else $error("periodic flag not cleared");

    chk_halt_holds: assert property (@(posedge CLK) disable iff (!RSTN)
        !q.start && !WR |=> $stable(q.sec) && $stable(q.day) && !q.upd)
        else $error("calendar moved while halted");

    chk_once_per_sec: assert property (@(posedge CLK) disable iff (!RSTN)
        q.upd |=> !q.upd)
        else $error("alarm evaluated twice in one second");
endmodule
`default_nettype wire

// >>> shared/rtcap_pkg.sv
// constants of the rtc alarm and periodic interrupt block
// assumes a single clock and an 8-bit register port with one-cycle read data
`default_nettype none
package rtcap_pkg;

    // ======================================================
    // register offsets
    localparam logic [7:0] A_SEC    = 8'h00;
    localparam logic [7:0] A_MIN    = 8'h01;
    localparam logic [7:0] A_HR     = 8'h02;
    localparam logic [7:0] A_WK     = 8'h03;
    localparam logic [7:0] A_DAY    = 8'h04;
    localparam logic [7:0] A_MON    = 8'h05;
    localparam logic [7:0] A_YR     = 8'h06;
    localparam logic [7:0] A_SECAL  = 8'h08;
    localparam logic [7:0] A_MINAL  = 8'h09;
    localparam logic [7:0] A_HRAL   = 8'h0a;
    localparam logic [7:0] A_WKAL   = 8'h0b;
    localparam logic [7:0] A_DAYAL  = 8'h0c;
    localparam logic [7:0] A_MONAL  = 8'h0d;
    localparam logic [7:0] A_YRAL   = 8'h0e;
    localparam logic [7:0] A_ALCTL  = 8'h10;
    localparam logic [7:0] A_RUNCTL = 8'h11;
    localparam logic [7:0] A_YRCTL  = 8'h12;
    localparam logic [7:0] A_ISTS   = 8'h13;
    localparam logic [7:0] A_IMSK   = 8'h14;

    // ======================================================
    // field positions and reset values
    localparam int ALM_EN_BIT = 7;
    localparam int AF_BIT     = 0;
    localparam int AIE_BIT    = 3;
    localparam int PEF_BIT    = 7;
    localparam int PSEL_LSB   = 4;
    localparam int OSC_BIT    = 3;
    localparam int DRST_BIT   = 1;
    localparam int START_BIT  = 0;
    localparam int YEAR_ALARM_ENABLE_BIT   = 7;
    localparam int IRQ_ALM    = 0;
    localparam int IRQ_PER    = 1;
    localparam logic RUN_START_RST = 1'b1;
    localparam logic RUN_OSC_RST   = 1'b1;
    localparam logic [2:0] PSEL_NONE = 3'h0;

    // ======================================================
    // timing: the divider makes a 256 Hz tick out of the 10 MHz clock
    localparam int CLK_HZ     = 10_000_000;
    localparam int TICK_HZ    = 256;
    localparam int DIV256_CYC = CLK_HZ / TICK_HZ;
    localparam int TCNT_W     = 9;
    localparam logic [TCNT_W-1:0] SEC_MASK = 9'h0ff;
    // log2 of the interval in 256 Hz ticks, indexed by interval select
    localparam logic [3:0] PER_LOG2 [0:7] = '{4'h0, 4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9};

    // ======================================================
    // bcd limits of the calendar
    localparam logic [7:0] BCD_ZERO  = 8'h00;
    localparam logic [7:0] BCD_ONE   = 8'h01;
    localparam logic [3:0] BCD_NINE  = 4'h9;
    localparam logic [7:0] SEC_LAST  = 8'h59;
    localparam logic [7:0] HR_LAST   = 8'h23;
    localparam logic [7:0] WK_LAST   = 8'h06;
    localparam logic [7:0] MON_LAST  = 8'h12;
    localparam logic [7:0] YR_LAST   = 8'h99;
    localparam logic [7:0] DAY_L31   = 8'h31;
    localparam logic [7:0] DAY_L30   = 8'h30;
    localparam logic [7:0] DAY_L29   = 8'h29;
    localparam logic [7:0] DAY_L28   = 8'h28;
    localparam logic [7:0] MON_FEB   = 8'h02;
    localparam logic [7:0] MON_APR   = 8'h04;
    localparam logic [7:0] MON_JUN   = 8'h06;
    localparam logic [7:0] MON_SEP   = 8'h09;
    localparam logic [7:0] MON_NOV   = 8'h11;

endpackage
`default_nettype wire

// >>> testbench/rtcap_top_tb.sv
// self-checking bench for the rtc alarm and periodic interrupt block
// assumes rtcap_top with a shortened divider count and the register map of rtcap_pkg
`timescale 1ns/1ps
`default_nettype none
module rtcap_top_tb
    import rtcap_pkg::*;
();
    // short divider keeps a calendar second at 4096 cycles
    localparam int DIV = 16;

    logic             CLK      = 1'b0;
    logic             RSTN     = 1'b0;
    logic [7:0]       ADDR     = 8'h00;
    logic [7:0]       WDATA    = 8'h00;
    logic             WR       = 1'b0;
    logic             RD       = 1'b0;
    wire logic [7:0]  RDATA;
    wire logic        IRQ;
    int               n_errors = 0;
    int               checks   = 0;
    int               cyc      = 0;
    logic [15:0]      exp_q[$];
    logic             pend     = 1'b0;
    logic [31:0]      rng      = 32'h57bd;
    int               ticks[8] = '{0, 1, 4, 16, 64, 128, 256, 512};

    rtcap_top #(.DIV_CYC(DIV)) u_dut (
        .CLK   (CLK),
        .RSTN  (RSTN),
        .ADDR  (ADDR),
        .WDATA (WDATA),
        .WR    (WR),
        .RD    (RD),
        .RDATA (RDATA),
        .IRQ   (IRQ)
    );

    // =====================================================
    // clock, cycle count, watchdog
    always #50 CLK = ~CLK;

    always @(posedge CLK) begin
        cyc <= cyc + 1;
    end

    // sized for about twice the expected run
    initial begin
        repeat (90000) @(posedge CLK);
        n_errors++;
        $display("unexpected at %0t ns: watchdog expired", $time);
        results();
    end

    // =====================================================
    // read monitor: data stand only in the cycle after the strobe
    always @(negedge CLK) begin
        logic [15:0] e;
        if (pend) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'h0000;
            checks++;
            if ((RDATA & e[7:0]) !== (e[15:8] & e[7:0])) begin
                n_errors++;
                $display("unexpected at %0t ns: read %h expected %h", $time, RDATA, e[15:8]);
            end
        end
        pend = RD;
    end

    // =====================================================
    // bus tasks and helpers
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLK);
        WR    <= 1'b0;
    endtask

    // the note goes on the queue before the strobe can be seen
    task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
        @(posedge CLK);
        exp_q.push_back({x, m});
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK);
        RD   <= 1'b0;
    endtask

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("unexpected at %0t ns: %s", $time, msg);
        end
    endtask

    // waits for a rising edge of the interrupt, so a stale level is not taken;
    // sampled on the falling edge, where the flop output has settled
    task automatic wait_irq(input int lim, output logic hit, output int t);
        logic prev;
        prev = 1'b1;
        hit  = 1'b0;
        t    = 0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(negedge CLK);
            if (IRQ === 1'b1 && !prev) begin
                hit = 1'b1;
                t   = cyc;
            end
            prev = (IRQ === 1'b1);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    task automatic results();
        $display("errors %0d, checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // =====================================================
    // main sequence
    initial begin
        logic       hit;
        int         t0;
        int         t1;
        logic [7:0] a;
        repeat (6) @(posedge CLK);
        RSTN <= 1'b1;
        // reset values, reserved bits, unmapped place
        rd(A_RUNCTL, 8'h09, 8'hff);
        rd(A_YRCTL, 8'h00, 8'hff);
        wr(A_YRCTL, 8'h80);
        rd(A_YRCTL, 8'h80, 8'hff);
        wr(8'h20, 8'h5a);
        rd(8'h20, 8'h00, 8'hff);
        // halted counters accept writes, running ones refuse them
        wr(A_RUNCTL, 8'h08);
        wr(A_YR, 8'h07);
        rd(A_YR, 8'h07, 8'hff);
        wr(A_SECAL, 8'hd9);
        wr(A_MINAL, 8'h80);
        wr(A_YRAL, 8'h06);
        wr(A_IMSK, 8'h01);
        wr(A_ALCTL, 8'h08);
        wr(A_SEC, 8'h58);
        wr(A_RUNCTL, 8'h09);
        wr(A_YR, 8'h42);
        rd(A_YR, 8'h07, 8'hff);
        // seconds write while running is dropped too; no carry is due this early
        wr(A_SEC, 8'h11);
        rd(A_SEC, 8'h58, 8'hff);
        // year enabled but different: seconds and minutes alone must not fire
        wait_irq(4500, hit, t0);
        chk(!hit, "alarm fired on year mismatch");
        rd(A_ALCTL, 8'h00, 8'h01);
        // seconds, minutes and year all match
        wr(A_RUNCTL, 8'h08);
        wr(A_SEC, 8'h58);
        wr(A_MIN, 8'h00);
        wr(A_YRAL, 8'h07);
        wr(A_RUNCTL, 8'h09);
        wait_irq(4500, hit, t0);
        chk(hit, "no alarm interrupt on full match");
        rd(A_ALCTL, 8'h09, 8'h09);
        // clearing in the matching second must not re-arm the flag
        wr(A_ALCTL, 8'h00);
        rd(A_ALCTL, 8'h00, 8'h01);
        wr(A_ISTS, 8'h01);
        repeat (3) @(negedge CLK);
        chk(IRQ === 1'b0, "interrupt stays after status clear");
        // interrupt enable off: flag only
        wr(A_RUNCTL, 8'h08);
        wr(A_SEC, 8'h58);
        wr(A_MIN, 8'h00);
        wr(A_RUNCTL, 8'h09);
        wait_irq(4500, hit, t0);
        chk(!hit, "alarm interrupt while disabled");
        rd(A_ALCTL, 8'h01, 8'h09);
        // periodic interval for every select code
        wr(A_IMSK, 8'h02);
        wr(A_ISTS, 8'h03);
        for (int c = 0; c < 8; c++) begin
            wr(A_RUNCTL, {1'b0, c[2:0], 4'h9});
            wr(A_ISTS, 8'h02);
            wait_irq((c == 0) ? 1200 : 2 * ticks[c] * DIV + 40, hit, t0);
            chk(hit === (c != 0), "periodic event presence");
            if (c != 0) begin
                wr(A_ISTS, 8'h02);
                rd(A_RUNCTL, {1'b0, c[2:0], 4'h9}, 8'hff);
                wait_irq(ticks[c] * DIV + 8, hit, t1);
                chk(hit && (t1 - t0 == ticks[c] * DIV), "periodic interval");
            end
        end
        // oscillator off stops the divider, so the fastest interval never comes
        wr(A_RUNCTL, 8'h10);
        wr(A_ISTS, 8'h02);
        wait_irq(200, hit, t0);
        chk(!hit, "periodic event with oscillator off");
        rd(A_RUNCTL, 8'h10, 8'hff);
        // random alarm field contents read back whole
        for (int i = 0; i < 12; i++) begin
            rng = xs(rng);
            a = A_SECAL + 8'(rng[15:8] % 8'd7);
            wr(a, rng[7:0]);
            rd(a, rng[7:0], 8'hff);
        end
        repeat (4) @(posedge CLK);
        results();
    end
endmodule
`default_nettype wire
